// File: src/instr_decoder_pkg.sv
/*
 * Shared constants and types for the 14-bit instruction decoder core:
 * register map, status fields, opcode encodings and the decode bundle.
 * Assumes a single 250 MHz clock domain and an APB register port.
 */
package instr_decoder_pkg;

    // Clock rate and instruction cycle length in clock periods.
    localparam int CLK_PERIOD_NS   = 4;
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    // Default widths and file addresses of neighbouring registers.
    localparam int PC_WIDTH   = 13;
    localparam int APB_AWIDTH = 8;
    localparam logic [6:0] TIMER0_ADDR = 7'h01;
    localparam logic [6:0] PORT_B_ADDR = 7'h06;

    // APB register byte offsets.
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] W_OFFSET      = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] PC_OFFSET     = 8'h0c;
    localparam logic [7:0] INSTR_OFFSET  = 8'h10;

    // Field positions.
    localparam int CTRL_RUN_BIT  = 0;
    localparam int ST_C_BIT      = 0;
    localparam int ST_HC_BIT     = 1;
    localparam int ST_Z_BIT      = 2;
    localparam int ST_PDN_BIT    = 3;
    localparam int ST_TMO_BIT    = 4;
    localparam int ST_SLEEP_BIT  = 5;

    // Reset values.
    localparam logic [7:0] W_RESET   = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h18;

    // Opcode classes (bits 13:12).
    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT  = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT  = 2'h3;

    // Byte-oriented opcodes (bits 11:8).
    localparam logic [3:0] OP_MOVE_W = 4'h0;
    localparam logic [3:0] OP_CLEAR  = 4'h1;
    localparam logic [3:0] OP_SUB_F  = 4'h2;
    localparam logic [3:0] OP_DEC    = 4'h3;
    localparam logic [3:0] OP_OR_F   = 4'h4;
    localparam logic [3:0] OP_AND_F  = 4'h5;
    localparam logic [3:0] OP_XOR_F  = 4'h6;
    localparam logic [3:0] OP_ADD_F  = 4'h7;
    localparam logic [3:0] OP_MOVE_F = 4'h8;
    localparam logic [3:0] OP_COMP   = 4'h9;
    localparam logic [3:0] OP_INC    = 4'ha;
    localparam logic [3:0] OP_DEC_SZ = 4'hb;
    localparam logic [3:0] OP_ROT_R  = 4'hc;
    localparam logic [3:0] OP_ROT_L  = 4'hd;
    localparam logic [3:0] OP_SWAP   = 4'he;
    localparam logic [3:0] OP_INC_SZ = 4'hf;

    // Control words under the move-W opcode with d clear (bits 6:0).
    localparam logic [6:0] CW_RETURN = 7'h08;
    localparam logic [6:0] CW_RETINT = 7'h09;
    localparam logic [6:0] CW_STANDBY = 7'h63;
    localparam logic [6:0] CW_WDT_CLR = 7'h64;

    // Literal opcodes (bits 11:8), don't-care bits removed.
    localparam logic [1:0] LIT_MOVE_HI = 2'h0;
    localparam logic [1:0] LIT_RET_HI  = 2'h1;
    localparam logic [3:0] LIT_OR      = 4'h8;
    localparam logic [3:0] LIT_AND     = 4'h9;
    localparam logic [3:0] LIT_XOR     = 4'ha;
    localparam logic [2:0] LIT_SUB_HI  = 3'h6;
    localparam logic [2:0] LIT_ADD_HI  = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_RUN   = 3'h2,
        ST_SLEEP = 3'h4
    } run_state_e;

    // Result of decoding one instruction against its operand.
    typedef struct packed {
        logic [7:0] res;
        logic       wr_w;
        logic       wr_f;
        logic       z_en;
        logic       c_en;
        logic       hc_en;
        logic       c;
        logic       hc;
        logic       skip;
        logic       jump;
        logic       call;
        logic       ret;
        logic       standby;
        logic       wdt_clr;
    } decode_s;

endpackage : instr_decoder_pkg

// File: src/instr_decoder.sv
/*
 * Instruction decoder and executor for a 14-bit instruction word core,
 * with a four-phase instruction cycle and an APB register port.
 * Assumes combinational program memory and file read data, an outside
 * call stack, and a host that starts the core through the run bit.
 */
// Function
// - add literal to W, update carries and zero
// - AND literal into W, Z only
// - OR literal into W, Z only
// - XOR literal into W, Z only
// - literal minus W into W, carries and zero
// - return with literal in W, two cycles
// - standby word sleeps, sets timeout, clears power-down
// - OR W with file to destination, Z
// - XOR W with file to destination, Z
// - rotate file left through carry
// - rotate file right through carry
// - decrement file, skip when zero
// - increment file, skip when zero
// - test bit, skip when clear
// - test bit, skip when set
// - port reads use pin levels, not latch
// - writing Timer0 clears its assigned prescaler
// - branch or true test adds NOP cycle
// - decode, read, process, write in Q1..Q4
// - d selects W or file destination
// - instruction cycle is four clock periods
`timescale 1ns/1ps
`default_nettype none

module instr_decoder #(
    parameter int         PC_W   = instr_decoder_pkg::PC_WIDTH,
    parameter int         AW     = instr_decoder_pkg::APB_AWIDTH,
    parameter logic [6:0] T0_ADR = instr_decoder_pkg::TIMER0_ADDR,
    parameter logic [6:0] PB_ADR = instr_decoder_pkg::PORT_B_ADDR
) (
    input  wire logic            CLK_I,
    input  wire logic            RST_I,
    input  wire logic            CE_I,
    input  wire logic            PSEL_I,
    input  wire logic            PENABLE_I,
    input  wire logic            PWRITE_I,
    input  wire logic [AW-1:0]   PADDR_I,
    input  wire logic [31:0]     PWDATA_I,
    output logic      [31:0]     PRDATA_O,
    output logic                 PREADY_O,
    output logic                 PSLVERR_O,
    input  wire logic [13:0]     INSTR_I,
    output logic      [PC_W-1:0] PC_O,
    output logic      [6:0]      FADDR_O,
    input  wire logic [7:0]      FRDATA_I,
    output logic      [7:0]      FWDATA_O,
    output logic                 FWE_O,
    input  wire logic [7:0]      PINS_I,
    input  wire logic            PSA_TIMER0_I,
    output logic                 PRESCALER_CLR_O,
    output logic                 WDT_CLR_O,
    output logic                 STACK_PUSH_O,
    output logic                 STACK_POP_O,
    output logic      [PC_W-1:0] STACK_DATA_O,
    input  wire logic [PC_W-1:0] RET_ADDR_I,
    input  wire logic            WAKE_I,
    output logic                 SLEEP_O
);

    instr_decoder_pkg::run_state_e state;
    instr_decoder_pkg::decode_s    dec;
    instr_decoder_pkg::decode_s    exe;

    logic [1:0]      phase;
    logic [13:0]     ir;
    logic [7:0]      opnd;
    logic [7:0]      w;
    logic [4:0]      flags;
    logic [PC_W-1:0] pc;
    logic            nop_cycle;
    logic            run;
    logic            pready;
    logic            commit;
    logic            apb_wr;
    logic [7:0]      add_a;
    logic [7:0]      add_b;
    logic            add_cin;
    logic [8:0]      sum;
    logic [4:0]      nib;
    logic [7:0]      bit_mask;
    logic            bit_val;

    // Q4 of a running cycle that is not a discarded NOP cycle.
    assign commit = state == instr_decoder_pkg::ST_RUN
                    && phase == instr_decoder_pkg::PH_Q4 && !nop_cycle;
    assign apb_wr = PSEL_I && PENABLE_I && pready && PWRITE_I;

    // Run state; sleep is left only by the wake input, not by a run write.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            state <= instr_decoder_pkg::ST_IDLE;
        else if (CE_I)
        begin
            unique case (state)
                instr_decoder_pkg::ST_IDLE:
                    if (run)
                        state <= instr_decoder_pkg::ST_RUN;
                instr_decoder_pkg::ST_RUN:
                    if (commit && exe.standby)
                        state <= instr_decoder_pkg::ST_SLEEP;
                    else if (!run && phase == instr_decoder_pkg::PH_Q4)
                        state <= instr_decoder_pkg::ST_IDLE;
                instr_decoder_pkg::ST_SLEEP:
                    if (WAKE_I)
                        state <= instr_decoder_pkg::ST_RUN;
                default:
                    state <= instr_decoder_pkg::ST_IDLE;
            endcase
        end
    end

    // One instruction cycle is four clocks, one per phase.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            phase <= instr_decoder_pkg::PH_Q1;
        else if (CE_I && state == instr_decoder_pkg::ST_RUN)
            phase <= phase + 2'h1;
    end

    // Q1 takes the word and file address, Q2 the operand, Q3 the result.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            ir      <= 14'h0000;
            FADDR_O <= 7'h00;
            opnd    <= 8'h00;
            exe     <= '0;
        end
        else if (CE_I && state == instr_decoder_pkg::ST_RUN)
        begin
            unique case (phase)
                instr_decoder_pkg::PH_Q1:
                begin
                    ir      <= INSTR_I;
                    FADDR_O <= INSTR_I[6:0];
                end
                instr_decoder_pkg::PH_Q2:
                    if (ir[13:12] == instr_decoder_pkg::CLS_LIT)
                        opnd <= ir[7:0];
                    else if (FADDR_O == PB_ADR)
                        opnd <= PINS_I;
                    else
                        opnd <= FRDATA_I;
                instr_decoder_pkg::PH_Q3:
                    exe <= dec;
                instr_decoder_pkg::PH_Q4:
                    ;
            endcase
        end
    end

    // Shared adder; subtraction adds the complement of W plus one.
    always_comb
    begin
        add_a   = opnd;
        add_b   = w;
        add_cin = 1'b0;
        if ((ir[13:12] == instr_decoder_pkg::CLS_BYTE
             && ir[11:8] == instr_decoder_pkg::OP_SUB_F)
            || (ir[13:12] == instr_decoder_pkg::CLS_LIT
             && ir[11:9] == instr_decoder_pkg::LIT_SUB_HI))
        begin
            add_b   = ~w;
            add_cin = 1'b1;
        end
    end

    assign sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
    assign nib = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]}
                 + {4'h0, add_cin};
    assign bit_mask = 8'h01 << ir[9:7];
    assign bit_val  = |(opnd & bit_mask);

    // Decode the latched word against its operand; unused codes do nothing.
    always_comb
    begin
        dec      = '0;
        dec.wr_f = ir[7];
        dec.wr_w = !ir[7];
        dec.z_en = 1'b1;
        unique case (ir[13:12])
            instr_decoder_pkg::CLS_BYTE:
                unique case (ir[11:8])
                    instr_decoder_pkg::OP_MOVE_W:
                    begin
                        dec.res  = w;
                        dec.wr_w = 1'b0;
                        dec.z_en = 1'b0;
                        if (!ir[7])
                        begin
                            // Control words; the rest is a plain NOP.
                            dec.ret = ir[6:0] == instr_decoder_pkg::CW_RETURN
                                || ir[6:0] == instr_decoder_pkg::CW_RETINT;
                            dec.standby =
                                ir[6:0] == instr_decoder_pkg::CW_STANDBY;
                            dec.wdt_clr =
                                ir[6:0] == instr_decoder_pkg::CW_WDT_CLR;
                        end
                    end
                    instr_decoder_pkg::OP_CLEAR:
                        dec.res = 8'h00;
                    instr_decoder_pkg::OP_SUB_F,
                    instr_decoder_pkg::OP_ADD_F:
                    begin
                        dec.res   = sum[7:0];
                        dec.c_en  = 1'b1;
                        dec.hc_en = 1'b1;
                    end
                    instr_decoder_pkg::OP_DEC:
                        dec.res = opnd - 8'h01;
                    instr_decoder_pkg::OP_OR_F:
                        dec.res = w | opnd;
                    instr_decoder_pkg::OP_AND_F:
                        dec.res = w & opnd;
                    instr_decoder_pkg::OP_XOR_F:
                        dec.res = w ^ opnd;
                    instr_decoder_pkg::OP_MOVE_F:
                        dec.res = opnd;
                    instr_decoder_pkg::OP_COMP:
                        dec.res = ~opnd;
                    instr_decoder_pkg::OP_INC:
                        dec.res = opnd + 8'h01;
                    instr_decoder_pkg::OP_DEC_SZ:
                    begin
                        dec.res  = opnd - 8'h01;
                        dec.z_en = 1'b0;
                        dec.skip = opnd == 8'h01;
                    end
                    instr_decoder_pkg::OP_ROT_R:
                    begin
                        dec.res  = {flags[instr_decoder_pkg::ST_C_BIT],
                                    opnd[7:1]};
                        dec.c    = opnd[0];
                        dec.c_en = 1'b1;
                        dec.z_en = 1'b0;
                    end
                    instr_decoder_pkg::OP_ROT_L:
                    begin
                        dec.res  = {opnd[6:0],
                                    flags[instr_decoder_pkg::ST_C_BIT]};
                        dec.c    = opnd[7];
                        dec.c_en = 1'b1;
                        dec.z_en = 1'b0;
                    end
                    instr_decoder_pkg::OP_SWAP:
                    begin
                        dec.res  = {opnd[3:0], opnd[7:4]};
                        dec.z_en = 1'b0;
                    end
                    instr_decoder_pkg::OP_INC_SZ:
                    begin
                        dec.res  = opnd + 8'h01;
                        dec.z_en = 1'b0;
                        dec.skip = opnd == 8'hff;
                    end
                endcase
            instr_decoder_pkg::CLS_BIT:
            begin
                // Set and clear write the file; tests only skip.
                dec.wr_w = 1'b0;
                dec.wr_f = !ir[11];
                dec.z_en = 1'b0;
                dec.res  = ir[10] ? (opnd | bit_mask) : (opnd & ~bit_mask);
                if (ir[11])
                    dec.skip = ir[10] ? bit_val : !bit_val;
            end
            instr_decoder_pkg::CLS_JUMP:
            begin
                dec.wr_w = 1'b0;
                dec.wr_f = 1'b0;
                dec.z_en = 1'b0;
                dec.jump = 1'b1;
                dec.call = !ir[11];
            end
            instr_decoder_pkg::CLS_LIT:
            begin
                dec.wr_w = 1'b1;
                dec.wr_f = 1'b0;
                dec.res  = opnd;
                dec.z_en = 1'b0;
                // Match only defined bits so don't-cares cannot matter.
                if (ir[11:10] == instr_decoder_pkg::LIT_RET_HI)
                    dec.ret = 1'b1;
                else if (ir[11:8] == instr_decoder_pkg::LIT_OR)
                begin
                    dec.res  = w | opnd;
                    dec.z_en = 1'b1;
                end
                else if (ir[11:8] == instr_decoder_pkg::LIT_AND)
                begin
                    dec.res  = w & opnd;
                    dec.z_en = 1'b1;
                end
                else if (ir[11:8] == instr_decoder_pkg::LIT_XOR)
                begin
                    dec.res  = w ^ opnd;
                    dec.z_en = 1'b1;
                end
                else if (ir[11:9] == instr_decoder_pkg::LIT_SUB_HI
                         || ir[11:9] == instr_decoder_pkg::LIT_ADD_HI)
                begin
                    dec.res   = sum[7:0];
                    dec.z_en  = 1'b1;
                    dec.c_en  = 1'b1;
                    dec.hc_en = 1'b1;
                end
                else if (ir[11:10] != instr_decoder_pkg::LIT_MOVE_HI)
                    dec.wr_w = 1'b0;
            end
        endcase
        if (dec.c_en && dec.hc_en)
        begin
            dec.c  = sum[8];
            dec.hc = nib[4];
        end
    end

    // Working register; a core write wins over a bus write.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            w <= instr_decoder_pkg::W_RESET;
        else if (CE_I)
        begin
            if (commit && exe.wr_w)
                w <= exe.res;
            else if (apb_wr && PADDR_I[7:0] == instr_decoder_pkg::W_OFFSET)
                w <= PWDATA_I[7:0];
        end
    end

    // Status flags: carry, half carry, zero, power-down and timeout.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            flags <= instr_decoder_pkg::FLAGS_RESET;
        else if (CE_I && commit)
        begin
            if (exe.c_en)
                flags[instr_decoder_pkg::ST_C_BIT] <= exe.c;
            if (exe.hc_en)
                flags[instr_decoder_pkg::ST_HC_BIT] <= exe.hc;
            if (exe.z_en)
                flags[instr_decoder_pkg::ST_Z_BIT] <= exe.res == 8'h00;
            if (exe.standby || exe.wdt_clr)
            begin
                flags[instr_decoder_pkg::ST_TMO_BIT] <= 1'b1;
                flags[instr_decoder_pkg::ST_PDN_BIT] <= exe.wdt_clr;
            end
        end
    end

    // Program counter; a skip steps over the next word as a NOP cycle.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            pc        <= '0;
            nop_cycle <= 1'b0;
        end
        else if (CE_I && state == instr_decoder_pkg::ST_RUN
                 && phase == instr_decoder_pkg::PH_Q4)
        begin
            nop_cycle <= commit && (exe.skip || exe.jump
                                    || exe.ret);
            if (!commit)
                pc <= pc;
            else if (exe.jump)
                pc <= {pc[PC_W-1:11], ir[10:0]};
            else if (exe.ret)
                pc <= RET_ADDR_I;
            else if (exe.skip)
                pc <= pc + PC_W'(2);
            else
                pc <= pc + PC_W'(1);
        end
    end

    // File write, stack and side-effect strobes, one clock wide.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            FWE_O           <= 1'b0;
            FWDATA_O        <= 8'h00;
            PRESCALER_CLR_O <= 1'b0;
            WDT_CLR_O       <= 1'b0;
            STACK_PUSH_O    <= 1'b0;
            STACK_POP_O     <= 1'b0;
            STACK_DATA_O    <= '0;
        end
        else if (CE_I)
        begin
            FWE_O           <= commit && exe.wr_f;
            FWDATA_O        <= commit ? exe.res : FWDATA_O;
            PRESCALER_CLR_O <= commit && exe.wr_f && FADDR_O == T0_ADR
                               && PSA_TIMER0_I;
            WDT_CLR_O       <= commit && (exe.wdt_clr || exe.standby);
            STACK_PUSH_O    <= commit && exe.call;
            STACK_POP_O     <= commit && exe.ret;
            if (commit && exe.call)
                STACK_DATA_O <= pc + PC_W'(1);
        end
    end

    // Run bit from the control register.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            run <= 1'b0;
        else if (CE_I && apb_wr
                 && PADDR_I[7:0] == instr_decoder_pkg::CTRL_OFFSET)
            run <= PWDATA_I[instr_decoder_pkg::CTRL_RUN_BIT];
    end

    // APB slave: one wait state, then read data and error with ready.
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            pready    <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end
        else if (CE_I)
        begin
            pready    <= PSEL_I && PENABLE_I && !pready;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            if (PSEL_I && PENABLE_I && !pready)
            begin
                unique case (PADDR_I)
                    AW'(instr_decoder_pkg::CTRL_OFFSET):
                        PRDATA_O <= {31'h0, run};
                    AW'(instr_decoder_pkg::W_OFFSET):
                        PRDATA_O <= {24'h0, w};
                    AW'(instr_decoder_pkg::STATUS_OFFSET):
                        PRDATA_O <= {26'h0, SLEEP_O, flags};
                    AW'(instr_decoder_pkg::PC_OFFSET):
                        PRDATA_O <= 32'(pc);
                    AW'(instr_decoder_pkg::INSTR_OFFSET):
                        PRDATA_O <= {18'h0, ir};
                    default:
                        PSLVERR_O <= 1'b1;
                endcase
            end
        end
    end

    assign PREADY_O = pready;
    assign PC_O     = pc;
    assign SLEEP_O  = state[2];

endmodule : instr_decoder

`default_nettype wire

// File: verification/decoder_monitor.sv
/* Port assertions for the instruction decoder.
   Assumes CE_I stays high and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module decoder_monitor #(
    parameter int PC_W = 13
) (
    input wire logic            CLK_I,
    input wire logic            RST_I,
    input wire logic            PSEL_I,
    input wire logic            PENABLE_I,
    input wire logic            PREADY_O,
    input wire logic            PSLVERR_O,
    input wire logic [PC_W-1:0] PC_O,
    input wire logic [6:0]      FADDR_O,
    input wire logic            FWE_O,
    input wire logic            PRESCALER_CLR_O,
    input wire logic            WDT_CLR_O,
    input wire logic            STACK_POP_O,
    input wire logic [PC_W-1:0] RET_ADDR_I,
    input wire logic            SLEEP_O
);
    // One domain, so reset masks every check from here.
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    ready_wait_a: assert property ($rose(PENABLE_I) && PSEL_I |=> PREADY_O)
        else $error("ready late");
    err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready too long");
    fwe_space_a: assert property (FWE_O |=> !FWE_O [*3])
        else $error("write strobes too close");
    pc_step_a: assert property ($changed(PC_O) |=> $stable(PC_O) [*3])
        else $error("pc moved inside a cycle");
    presc_clr_a: assert property (PRESCALER_CLR_O |-> FWE_O &&
        FADDR_O == instr_decoder_pkg::TIMER0_ADDR) else $error("bad clear");
    pop_pc_a: assert property (STACK_POP_O |-> PC_O == $past(RET_ADDR_I))
        else $error("return target wrong");
    sleep_wdt_a: assert property ($rose(SLEEP_O) |-> WDT_CLR_O ||
        $past(WDT_CLR_O)) else $error("standby without clear");
endmodule : decoder_monitor
bind instr_decoder decoder_monitor #(.PC_W(PC_W)) mon (
    .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PC_O(PC_O),
    .FADDR_O(FADDR_O), .FWE_O(FWE_O), .PRESCALER_CLR_O(PRESCALER_CLR_O),
    .WDT_CLR_O(WDT_CLR_O), .STACK_POP_O(STACK_POP_O),
    .RET_ADDR_I(RET_ADDR_I), .SLEEP_O(SLEEP_O));
`default_nettype wire

// File: verification/prog_file_model.sv
/* Program memory, file register and one-entry call stack model.
   Assumes the core reads mid-cycle and writes on its strobe. */
`timescale 1ns/1ps
`default_nettype none
module prog_file_model (
    input  wire logic        clk_i,
    input  wire logic [12:0] pc_i,
    input  wire logic [6:0]  faddr_i,
    input  wire logic [7:0]  fwdata_i,
    input  wire logic        fwe_i,
    input  wire logic        push_i,
    input  wire logic [12:0] sdata_i,
    output logic      [13:0] instr_o,
    output logic      [7:0]  frdata_o,
    output logic      [12:0] ret_o
);
    // Operands the test program starts from; the rest reads zero.
    logic [7:0]  ram [128] = '{7'h20: 8'h03, 7'h21: 8'h0f, 7'h22: 8'h81,
        7'h23: 8'h02, 7'h24: 8'h01, 7'h25: 8'hff, 7'h06: 8'hff,
        default: 8'h00};
    logic [13:0] rom [23] = '{14'h3010, 14'h3f15, 14'h395f, 14'h38a0,
        14'h3aff, 14'h04a0, 14'h06a1, 14'h0da2, 14'h0ca3, 14'h0ba4,
        14'h3000, 14'h0fa5, 14'h3000, 14'h1825, 14'h3000, 14'h1ca0,
        14'h3000, 14'h0486, 14'h0481, 14'h3d5a, 14'h2016, 14'h0063,
        14'h3677};
    // Past the program the core sees a harmless word, never an unknown.
    assign instr_o  = (pc_i < 13'h017) ? rom[pc_i] : 14'h0000;
    assign frdata_o = ram[faddr_i];
    // A push keeps the return address until the next pop uses it.
    always @(posedge clk_i)
        if (push_i)
            ret_o <= sdata_i;
    // The write lands while the file address still stands.
    always @(posedge clk_i)
        if (fwe_i)
            ram[faddr_i] <= fwdata_i;
endmodule : prog_file_model
`default_nettype wire

// File: verification/testbench.sv
/* Self-checking bench: APB register tests and one program run.
   Assumes the model program ends in standby at address 15h. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, prdy, perr, fwe, pclr, wdt, pop, slp, e, psh;
    logic [7:0]  pa = 8'h00, frd, fwd;
    logic [31:0] pwd = 32'h0, prd, q;
    logic [13:0] ins;
    logic [12:0] pc, ret, sd;
    logic [6:0]  fad;
    int          err_total = 0, n_compared = 0, n_ev = 0;
    localparam logic [6:0] FA [8] = '{7'h20, 7'h21, 7'h22, 7'h23,
        7'h24, 7'h25, 7'h06, 7'h01};
    localparam logic [7:0] FE [8] = '{8'h5b, 8'h55, 8'h02, 8'h81,
        8'h00, 8'h00, 8'h5f, 8'h5a};
    instr_decoder dut (
        .CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
        .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .INSTR_I(ins), .PC_O(pc), .FADDR_O(fad), .FRDATA_I(frd),
        .FWDATA_O(fwd), .FWE_O(fwe), .PINS_I(8'h0f),
        .PSA_TIMER0_I(1'b1), .PRESCALER_CLR_O(pclr), .WDT_CLR_O(wdt),
        .STACK_PUSH_O(psh), .STACK_POP_O(pop), .STACK_DATA_O(sd),
        .RET_ADDR_I(ret), .WAKE_I(1'b0), .SLEEP_O(slp));
    prog_file_model mdl (.clk_i(clk), .pc_i(pc), .faddr_i(fad),
        .fwdata_i(fwd), .fwe_i(fwe), .instr_o(ins), .frdata_o(frd),
        .push_i(psh), .sdata_i(sd), .ret_o(ret));
    // A 4 ns clock; each side-effect strobe is counted as one event.
    always #2 clk = ~clk;
    always @(posedge clk)
        n_ev += int'(pclr === 1'b1) + int'(pop === 1'b1)
            + int'(wdt === 1'b1) + int'(psh === 1'b1);
    // Holds the request until ready is seen at an edge, then releases.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1 && ++n < 20);
        if (n == 20) err_total++;
        q = prd;
        e = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // Main sequence: register map first, then the program run.
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h18);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h18);
        apb(1'b1, 8'h04, 32'hffff_ffa5);
        apb(1'b0, 8'h04, 32'h0);
        chk(q, 32'ha5);
        apb(1'b0, 8'h14, 32'h0);
        chk({q[30:0], e}, 32'h1);
        $display("test registers done");
        apb(1'b1, 8'h00, 32'h1);
        for (int n = 0; n < 600 && slp !== 1'b1; n++) @(posedge clk);
        chk(slp, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h77);
        apb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h37);
        apb(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h16);
        foreach (FA[i]) chk(mdl.ram[FA[i]], FE[i]);
        chk(n_ev, 4);
        chk(ret, 32'h15);
        $display("test program done");
        finish_test();
    end
    // Cuts a hang short well past the expected run length.
    initial
    begin
        #20000;
        err_total++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
